// *** src/psrc_top.sv ***
// Top of the reset and pin-strap configuration loader
// Summary of operation
// - During reset, media-select pin low picks twisted pair, high picks fiber.
// - In fiber mode the media-select pin serves as signal detect afterwards.
// - Reset is entered when reset pin low OR software reset bit set.
// - Internal reset is held 258 us after the reset request goes away.
// - Pause strap high adds pause to advertised abilities.
// - Sleep strap high permits low-power sleep mode.
// - In managed mode software sleep bit overrides the sleep strap.
// - Management address comes from the address strap inputs.
// - Management enabled: media, pause and sleep straps give only initial values, software then controls them; the address stays strapped.
`timescale 1ns/1ps
module psrc_top #(
  parameter int ADDR_WIDTH = psrc_pkg::ADDR_WIDTH,
  parameter int STRETCH_CYCLES = psrc_pkg::RESET_STRETCH_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic resetPinN,
  input wire logic softwareReset,
  input wire logic media_select_signal_detect_pin,
  input wire logic [ADDR_WIDTH-1:0] phy_address_strap,
  input wire logic pauseStrap,
  input wire logic sleepStrap,
  input wire logic management_disable_pin,
  input wire logic softwareWrite,
  input wire logic softwareMedia,
  input wire logic softwarePause,
  input wire logic softwareSleep,
  output logic internalReset,
  output logic resetRequest,
  output logic mediaFiber,
  output logic signalDetect,
  output logic [ADDR_WIDTH-1:0] phyAddress,
  output logic advertisePause,
  output logic sleepEnable,
  output logic managementEnabled,
  output logic configValid
);
  logic stretchDone;
  logic sdSample;

  assign resetRequest = !resetPinN || softwareReset;

  psrc_reset_stretch #(
    .STRETCH_CYCLES(STRETCH_CYCLES)
  ) stretcher (
    .clock(clock),
    .reset(reset),
    .resetRequest(resetRequest),
    .internalReset(internalReset),
    .stretchDone(stretchDone)
  );

  // Straps caught by a clocked process at the close of the stretch, not under async reset
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      phyAddress <= ADDR_WIDTH'(psrc_pkg::ADDR_RESET_VALUE);
      managementEnabled <= !psrc_pkg::MGMT_DISABLE_RESET_VALUE;
    end else if (stretchDone) begin
      phyAddress <= phy_address_strap;
      managementEnabled <= !management_disable_pin;
    end
  end

  // Effective settings: straps load them, software may change them when managed
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mediaFiber <= psrc_pkg::MEDIA_RESET_VALUE;
      advertisePause <= psrc_pkg::PAUSE_RESET_VALUE;
      sleepEnable <= psrc_pkg::SLEEP_RESET_VALUE;
    end else if (stretchDone) begin
      mediaFiber <= media_select_signal_detect_pin;
      advertisePause <= pauseStrap;
      sleepEnable <= sleepStrap;
    end else if (!internalReset && managementEnabled && softwareWrite) begin
      mediaFiber <= softwareMedia;
      advertisePause <= softwarePause;
      sleepEnable <= softwareSleep;
    end
  end

  // Signal detect only meaningful once running in fiber mode
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sdSample <= 1'b0;
      signalDetect <= 1'b0;
    end else begin
      sdSample <= media_select_signal_detect_pin;
      signalDetect <= sdSample && !internalReset && (mediaFiber == psrc_pkg::MEDIA_FIBER);
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      configValid <= 1'b0;
    end else begin
      configValid <= !internalReset && !resetRequest;
    end
  end
endmodule

// *** src/psrc_pkg.sv ***
// Package of constants for the strap and reset configuration block
package psrc_pkg;
  localparam int CLOCK_FREQ_HZ = 50_000_000;
  localparam int RESET_STRETCH_US = 258;
  // Nominal stretch, rounded down to whole cycles
  localparam int RESET_STRETCH_CYCLES = (RESET_STRETCH_US * (CLOCK_FREQ_HZ / 1_000_000));
  localparam int ADDR_WIDTH = 5;
  localparam logic MEDIA_TWISTED_PAIR = 1'b0;
  localparam logic MEDIA_FIBER = 1'b1;
  localparam logic [4:0] ADDR_RESET_VALUE = 5'h00;
  localparam logic MEDIA_RESET_VALUE = 1'b0;
  localparam logic PAUSE_RESET_VALUE = 1'b0;
  localparam logic SLEEP_RESET_VALUE = 1'b0;
  localparam logic MGMT_DISABLE_RESET_VALUE = 1'b0;
  typedef enum logic [1:0] {
    PSRC_IN_RESET = 2'b00,
    PSRC_STRETCH = 2'b01,
    PSRC_RUN = 2'b10
  } psrc_state_t;
endpackage

// *** src/psrc_reset_stretch.sv ***
// Reset stretcher: holds internal reset for a fixed count after the request drops
`timescale 1ns/1ps
module psrc_reset_stretch #(
  parameter int STRETCH_CYCLES = psrc_pkg::RESET_STRETCH_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic resetRequest,
  output logic internalReset,
  output logic stretchDone
);
  localparam int CW = $clog2(STRETCH_CYCLES + 1);
  localparam logic [CW-1:0] LAST_COUNT = CW'(STRETCH_CYCLES - 1);
  psrc_pkg::psrc_state_t state;
  logic [CW-1:0] count;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state <= psrc_pkg::PSRC_IN_RESET;
      count <= '0;
    end else begin
      case (state)
        psrc_pkg::PSRC_IN_RESET: begin
          count <= '0;
          if (!resetRequest) begin
            state <= psrc_pkg::PSRC_STRETCH;
          end
        end
        psrc_pkg::PSRC_STRETCH: begin
          // A new request restarts the whole stretch
          if (resetRequest) begin
            state <= psrc_pkg::PSRC_IN_RESET;
            count <= '0;
          end else if (count == LAST_COUNT) begin
            state <= psrc_pkg::PSRC_RUN;
          end else begin
            count <= count + CW'(1);
          end
        end
        psrc_pkg::PSRC_RUN: begin
          count <= '0;
          if (resetRequest) begin
            state <= psrc_pkg::PSRC_IN_RESET;
          end
        end
        default: begin
          state <= psrc_pkg::PSRC_IN_RESET;
          count <= '0;
        end
      endcase
    end
  end

  assign internalReset = (state != psrc_pkg::PSRC_RUN);
  assign stretchDone = (state == psrc_pkg::PSRC_STRETCH) && !resetRequest && (count == LAST_COUNT);
endmodule

// *** tb/psrc_strap_model.sv ***
// Board straps and fiber transceiver on the media pin
`timescale 1ns/1ps
module psrc_strap_model (
  input wire logic internalReset,
  input wire logic fiberStrap,
  input wire logic sdLevel,
  output logic mediaPin
);
  // Twisted pair boards ground the pin
  assign mediaPin = internalReset ? fiberStrap : fiberStrap & sdLevel;
endmodule

// *** tb/psrc_top_asserts.sv ***
// Assertions on the loader ports
`timescale 1ns/1ps
module psrc_top_asserts #(
  parameter int ADDR_WIDTH = 5
) (
  input wire logic clock, reset, resetPinN, softwareReset, media_select_signal_detect_pin,
  input wire logic [ADDR_WIDTH-1:0] phy_address_strap, phyAddress,
  input wire logic pauseStrap, sleepStrap, softwareWrite, softwareSleep, internalReset,
  input wire logic resetRequest, mediaFiber, advertisePause, sleepEnable, managementEnabled
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  property p_req; (!resetPinN || softwareReset) |-> resetRequest ##1 internalReset; endproperty
  a_req: assert property (p_req) else $error("reset not entered");
  property p_str; $fell(resetRequest) |-> internalReset [*8]; endproperty
  a_str: assert property (p_str) else $error("stretch too short");
  property p_med; $fell(internalReset) |-> mediaFiber == $past(media_select_signal_detect_pin); endproperty
  a_med: assert property (p_med) else $error("media not latched");
  property p_adr; $fell(internalReset) |-> phyAddress == $past(phy_address_strap); endproperty
  a_adr: assert property (p_adr) else $error("address not latched");
  property p_pau; $fell(internalReset) |-> advertisePause == $past(pauseStrap); endproperty
  a_pau: assert property (p_pau) else $error("pause not latched");
  property p_slp; $fell(internalReset) |-> sleepEnable == $past(sleepStrap); endproperty
  a_slp: assert property (p_slp) else $error("sleep not latched");
  property p_hld; !internalReset |=> $stable(phyAddress); endproperty
  a_hld: assert property (p_hld) else $error("address moved");
  property p_sw; softwareWrite && !internalReset && managementEnabled |=> sleepEnable == $past(softwareSleep); endproperty
  a_sw: assert property (p_sw) else $error("sleep write lost");
  property p_lock; !managementEnabled && !internalReset && !resetRequest |=> $stable(sleepEnable); endproperty
  a_lock: assert property (p_lock) else $error("write taken while unmanaged");
endmodule
bind psrc_top psrc_top_asserts #(.ADDR_WIDTH(ADDR_WIDTH)) u_psrc_top_asserts(.clock, .reset, .resetPinN,
  .softwareReset, .media_select_signal_detect_pin, .phy_address_strap, .phyAddress, .pauseStrap, .sleepStrap,
  .softwareWrite, .softwareSleep, .internalReset, .resetRequest, .mediaFiber, .advertisePause, .sleepEnable,
  .managementEnabled);

// *** tb/psrc_top_tb.sv ***
// Bench for the strap and reset loader
`timescale 1ns/1ps
module psrc_top_tb;
  logic clock = 0, reset = 1, resetPinN = 1, softwareReset = 0, fiberStrap = 0, sdLevel = 0, mdis = 0;
  logic pauseStrap = 0, sleepStrap = 0, softwareWrite = 0, softwareMedia = 0, softwarePause = 0;
  logic softwareSleep = 0, internalReset, resetRequest, mediaFiber, signalDetect, advertisePause;
  logic sleepEnable, managementEnabled, mediaPin, configValid;
  logic [4:0] strap = 5'h00, phyAddress;
  int num_errors = 0, n_compared = 0, n;
  psrc_top #(.STRETCH_CYCLES(10)) u_psrc_top(.clock, .reset, .resetPinN, .softwareReset,
    .media_select_signal_detect_pin(mediaPin), .phy_address_strap(strap), .pauseStrap, .sleepStrap,
    .management_disable_pin(mdis), .softwareWrite, .softwareMedia, .softwarePause, .softwareSleep,
    .internalReset, .resetRequest, .mediaFiber, .signalDetect, .phyAddress, .advertisePause,
    .sleepEnable, .managementEnabled, .configValid);
  psrc_strap_model u_psrc_strap_model(.internalReset, .fiberStrap, .sdLevel, .mediaPin);
  initial forever #10 clock = ~clock;
  task automatic check(string nm, logic [8:0] exp, logic [8:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic give_verdict();
    if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic rst(logic sw, logic med, logic [4:0] a, logic p, logic s, logic d);
    @(negedge clock);
    {fiberStrap, strap, pauseStrap, sleepStrap, mdis} = {med, a, p, s, d};
    softwareReset = sw;
    resetPinN = sw;
    repeat (2) @(negedge clock);
    check("rst", 9'h003, {7'h00, resetRequest, internalReset});
    {softwareReset, resetPinN} = 2'b01;
    // Bounded wait in case the stretch never ends
    for (n = 0; internalReset !== 1'b0 && n < 50; n++) @(negedge clock);
    // One edge to leave the held state, then ten counted stretch edges
    check("stretch", 9'h00b, n[8:0]);
    check("cfg", {med, a, p, s, !d}, {mediaFiber, phyAddress, advertisePause, sleepEnable, managementEnabled});
  endtask
  task automatic wr(logic s);
    @(negedge clock);
    {softwareWrite, softwareMedia, softwarePause, softwareSleep} = {1'b1, mediaFiber, advertisePause, s};
    @(negedge clock);
    softwareWrite = 0;
  endtask
  initial begin
    repeat (8) @(negedge clock);
    reset = 0;
    rst(0, 0, 5'h15, 1, 0, 0);
    strap = 5'h0a;
    sdLevel = 1;
    repeat (4) @(negedge clock);
    check("hold", 9'h015, {4'h0, phyAddress});
    check("tp_sd", 9'h000, {8'h00, signalDetect});
    check("valid", 9'h001, {8'h00, configValid});
    rst(1, 1, 5'h0a, 0, 1, 0);
    repeat (4) @(negedge clock);
    check("sd", 9'h001, {8'h00, signalDetect});
    wr(0);
    check("sw_sleep", 9'h000, {8'h00, sleepEnable});
    rst(0, 0, 5'h1f, 1, 1, 1);
    wr(0);
    check("locked", 9'h001, {8'h00, sleepEnable});
    give_verdict();
  end
  initial begin
    #100us;
    num_errors++;
    give_verdict();
  end
endmodule
